// [rtl/spc_sync_port.sv]
// Sync pin port configuration and pin timing of the video encoder
`timescale 1ns/100ps
module spc_sync_port
    import spc_pkg::*;
#(
    parameter int LINE_PIXELS      = SPC_LINE_PIXELS,      // Pixel clocks per line
    parameter int FIELD_HALF_LINES = SPC_FIELD_HALF_LINES, // Half lines per field
    parameter int VS_HALF_LINES    = SPC_VS_HALF_LINES     // Vertical sync width in half lines
)
(
    input  wire logic        core_clk_i,             // Pixel clock
    input  wire logic        reset_i,                // Synchronous reset
    input  wire logic        reg_wr_i,               // Register write strobe
    input  wire logic        reg_rd_i,               // Register read strobe
    input  wire logic [7:0]  reg_addr_i,             // Register subaddress
    input  wire logic [7:0]  reg_wdata_i,            // Write data
    output logic      [7:0]  reg_rdata_o,            // Read data
    input  wire logic        sync_method_select_i,   // High takes horizontal sync from 656 input, vertical sync off
    input  wire logic        frame_sync_656_i,       // Decoded 656 frame sync pulse
    input  wire logic        phase_alternation_mode_i, // PHASE_ALTERNATION_MODE encoding
    input  wire logic        sequential_colour_mode_i, // SEQUENTIAL_COLOUR_MODE encoding
    input  wire logic [10:0] pulse_start_position_i, // Second pin pulse start
    input  wire logic [10:0] pulse_end_position_i,   // Second pin pulse end
    input  wire logic [8:0]  first_active_line_i,    // First active line
    input  wire logic [8:0]  last_active_line_i,     // Last active line
    input  wire logic        sync_pin_one_i,         // First pin input level
    output logic             sync_pin_one_o,         // First pin output level
    output logic             sync_pin_one_oe_n_o,    // First pin drive enable, low drives
    input  wire logic        sync_pin_two_i,         // Second pin input level
    output logic             sync_pin_two_o,         // Second pin output level
    output logic             sync_pin_two_oe_n_o,    // Second pin drive enable, low drives
    output logic             h_sync_event_o,         // Horizontal sync taken
    output logic             v_sync_event_o,         // Vertical sync taken
    output logic      [10:0] hpos_o,                 // Horizontal position
    output logic      [9:0]  half_line_o,            // Half line within field
    output logic             field_odd_o,            // Odd field flag
    output logic             int_blank_o             // Internal blanking from second pin
);

    logic [7:0]  cfg;
    logic [10:0] horiz_trigger_phase;
    logic [4:0]  vert_trigger_phase;
    logic [10:0] hcnt;
    logic [9:0]  hl_cnt;
    logic        field_odd;
    logic [3:0]  field_sequence_sync_cnt;
    logic [3:0]  field_sequence_sync_len;
    logic        one_active;
    logic        one_edge;
    logic        two_active;
    logic        two_edge;
    logic        next_h_event;
    logic        next_v_event;
    logic        half_tick;
    logic        field_wrap;
    logic        vs_active;
    logic        in_h;
    logic        vblank;
    logic        next_pin_one;
    logic        next_pin_two;
    spc_type_t   pin_type;

    assign pin_type = spc_type_t'(cfg[SPC_BIT_TYPE_HI:SPC_BIT_TYPE_LO]);

    // Register writes
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            cfg   <= SPC_CONFIG_RESET;
            horiz_trigger_phase <= SPC_HORIZ_TRIGGER_PHASE_RESET;
            vert_trigger_phase <= SPC_VERT_TRIGGER_PHASE_RESET;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                SPC_ADDR_SYNC_PIN_CONFIG: cfg <= reg_wdata_i;
                SPC_ADDR_HORIZ_TRIGGER_PHASE_LO:        horiz_trigger_phase[7:0] <= reg_wdata_i;
                SPC_ADDR_HORIZ_TRIGGER_PHASE_HI:
                begin
                    horiz_trigger_phase[10:8] <= reg_wdata_i[SPC_HORIZ_TRIGGER_PHASE_HI_MSB:SPC_HORIZ_TRIGGER_PHASE_HI_LSB];
                    vert_trigger_phase       <= reg_wdata_i[SPC_VERT_TRIGGER_PHASE_MSB:0];
                end
                default: ;
            endcase
        end
    end

    // Register reads, unmapped addresses give zero
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                SPC_ADDR_SYNC_PIN_CONFIG: reg_rdata_o <= cfg;
                SPC_ADDR_HORIZ_TRIGGER_PHASE_LO:        reg_rdata_o <= horiz_trigger_phase[7:0];
                SPC_ADDR_HORIZ_TRIGGER_PHASE_HI:        reg_rdata_o <= {horiz_trigger_phase[10:8], vert_trigger_phase};
                default:                  reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Pin sampling with selected polarity
    spc_edge_detect u_edge_one
    (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .pin_i      (sync_pin_one_i),
        .falling_i  (cfg[SPC_BIT_ONE_POL]),
        .active_o   (one_active),
        .edge_o     (one_edge)
    );

    spc_edge_detect u_edge_two
    (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .pin_i      (sync_pin_two_i),
        .falling_i  (cfg[SPC_BIT_TWO_POL]),
        .active_o   (two_active),
        .edge_o     (two_edge)
    );

    // Horizontal and vertical sync source selection
    always_comb
    begin
        next_h_event = 1'b0;
        if (sync_method_select_i)
            next_h_event = frame_sync_656_i;
        else if (cfg[SPC_BIT_HSRC])
            next_h_event = two_edge & ~cfg[SPC_BIT_TWO_DIR];
        else
            next_h_event = one_edge & ~cfg[SPC_BIT_ONE_DIR];
        next_v_event = one_edge & ~cfg[SPC_BIT_ONE_DIR] & ~sync_method_select_i;
    end

    // Registered sync events
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            h_sync_event_o <= 1'b0;
            v_sync_event_o <= 1'b0;
        end
        else
        begin
            h_sync_event_o <= next_h_event;
            v_sync_event_o <= next_v_event;
        end
    end

    // Horizontal counter, loaded with the trigger phase on sync
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            hcnt <= 11'h000;
        else if (next_h_event)
            hcnt <= horiz_trigger_phase;
        else if (hcnt >= 11'(LINE_PIXELS - 1))
            hcnt <= 11'h000;
        else
            hcnt <= hcnt + 11'h001;
    end

    assign half_tick  = (hcnt == 11'(LINE_PIXELS - 1)) || (hcnt == 11'(LINE_PIXELS / 2 - 1));
    assign field_wrap = half_tick && (hl_cnt >= 10'(FIELD_HALF_LINES - 1));

    // Half line counter, loaded with the vertical phase on sync
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            hl_cnt <= 10'h000;
        else if (next_v_event)
            hl_cnt <= {5'h00, vert_trigger_phase};
        else if (field_wrap)
            hl_cnt <= 10'h000;
        else if (half_tick)
            hl_cnt <= hl_cnt + 10'h001;
    end

    // Field parity and field sequence count
    assign field_sequence_sync_len = sequential_colour_mode_i  ? SPC_FIELD_SEQUENCE_SYNC_SEQUENTIAL_COLOUR_MODE :
                      phase_alternation_mode_i ? SPC_FIELD_SEQUENCE_SYNC_PAL : SPC_FIELD_SEQUENCE_SYNC_NTSC;

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            field_odd <= 1'b0;
            field_sequence_sync_cnt  <= 4'h0;
        end
        else if (field_wrap)
        begin
            field_odd <= ~field_odd;
            field_sequence_sync_cnt  <= (field_sequence_sync_cnt >= field_sequence_sync_len - 4'h1) ? 4'h0 : field_sequence_sync_cnt + 4'h1;
        end
    end

    assign hpos_o      = hcnt;
    assign half_line_o = hl_cnt;
    assign field_odd_o = field_odd;

    // Timing windows
    assign vs_active = hl_cnt < 10'(VS_HALF_LINES);
    assign in_h      = (hcnt >= pulse_start_position_i) && (hcnt < pulse_end_position_i);
    assign vblank    = (hl_cnt[9:1] < first_active_line_i) || (hl_cnt[9:1] > last_active_line_i);

    // First pin output signal by type
    always_comb
    begin
        case (pin_type)
            SPC_TYPE_VSYNC: next_pin_one = vs_active;
            SPC_TYPE_FRAME: next_pin_one = field_odd;
            SPC_TYPE_FIELD_SEQUENCE_SYNC:  next_pin_one = vs_active && (field_sequence_sync_cnt == 4'h0);
            default:        next_pin_one = 1'b0;
        endcase
    end

    // Second pin output signal by blanking mode
    assign next_pin_two = cfg[SPC_BIT_CBLANK] ? (in_h & ~vblank) : in_h;

    // Pin drivers with polarity
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            sync_pin_one_o <= 1'b0;
            sync_pin_two_o <= 1'b0;
        end
        else
        begin
            sync_pin_one_o <= next_pin_one ^ cfg[SPC_BIT_ONE_POL];
            sync_pin_two_o <= next_pin_two ^ cfg[SPC_BIT_TWO_POL];
        end
    end

    assign sync_pin_one_oe_n_o = ~cfg[SPC_BIT_ONE_DIR];
    assign sync_pin_two_oe_n_o = ~cfg[SPC_BIT_TWO_DIR];

    // Internal blanking from the second pin input
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            int_blank_o <= 1'b0;
        else
            int_blank_o <= cfg[SPC_BIT_CBLANK] & ~cfg[SPC_BIT_TWO_DIR]
                           & ~sync_method_select_i & two_active;
    end

    // Checks
    chk_dir_one_write: assert property (@(posedge core_clk_i) disable iff (reset_i)
        reg_wr_i && reg_addr_i == SPC_ADDR_SYNC_PIN_CONFIG |=> sync_pin_one_oe_n_o == !$past(reg_wdata_i[4]))
        else $error("first pin direction does not follow bit 4");

    chk_dir_two_write: assert property (@(posedge core_clk_i) disable iff (reset_i)
        reg_wr_i && reg_addr_i == SPC_ADDR_SYNC_PIN_CONFIG |=> sync_pin_two_oe_n_o == !$past(reg_wdata_i[1]))
        else $error("second pin direction does not follow bit 1");

    chk_hsrc_pin_one: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !sync_method_select_i && !cfg[5] && !cfg[4] && one_edge |=> h_sync_event_o)
        else $error("first pin edge did not give horizontal sync");

    chk_hsrc_frame_656: assert property (@(posedge core_clk_i) disable iff (reset_i)
        sync_method_select_i |=> h_sync_event_o == $past(frame_sync_656_i))
        else $error("656 frame sync not used as horizontal sync");

    chk_hsrc_pin_two: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !sync_method_select_i && cfg[5] && !cfg[1] |=> h_sync_event_o == $past(two_edge))
        else $error("second pin edge not used as horizontal sync");

    chk_horiz_trigger_phase_load: assert property (@(posedge core_clk_i) disable iff (reset_i)
        next_h_event |=> hpos_o == $past(horiz_trigger_phase))
        else $error("horizontal counter not loaded with trigger phase");

    chk_vert_trigger_phase_load: assert property (@(posedge core_clk_i) disable iff (reset_i)
        next_v_event |=> half_line_o == {5'h00, $past(vert_trigger_phase)})
        else $error("half line counter not loaded with vertical phase");

    chk_pin_one_pol: assert property (@(posedge core_clk_i) disable iff (reset_i)
        cfg[7:6] == 2'b00 && $stable(cfg) |=> sync_pin_one_o == ($past(vs_active) ^ $past(cfg[3])))
        else $error("first pin vertical sync level or polarity wrong");

    chk_horizontal_reference_pulse_out: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !cfg[2] && $stable(cfg) && in_h |=> sync_pin_two_o == !$past(cfg[0]))
        else $error("reference pulse missing inside window");

    chk_cblank_vbl: assert property (@(posedge core_clk_i) disable iff (reset_i)
        cfg[2] && $stable(cfg) && vblank |=> sync_pin_two_o == $past(cfg[0]))
        else $error("blanking-not pulse present in vertical blanking");

    chk_blank_input: assert property (@(posedge core_clk_i) disable iff (reset_i)
        cfg[2] && !cfg[1] && !sync_method_select_i |=> int_blank_o == $past(two_active))
        else $error("internal blanking does not follow second pin");

    chk_field_sequence_sync_count: assert property (@(posedge core_clk_i) disable iff (reset_i)
        field_sequence_sync_cnt < field_sequence_sync_len || $changed(field_sequence_sync_len))
        else $error("field sequence count out of range");

    chk_edge_single: assert property (@(posedge core_clk_i) disable iff (reset_i)
        one_edge && $stable(cfg[SPC_BIT_ONE_POL])
        && !$past(reset_i) && !$past(reset_i, 2) && !$past(reset_i, 3)
        |-> ($past(sync_pin_one_i, 2) != cfg[SPC_BIT_ONE_POL]) && ($past(sync_pin_one_i, 3) == cfg[SPC_BIT_ONE_POL]))
        else $error("first pin edge not seen two cycles after the pin changed");

endmodule // spc_sync_port

// [rtl/spc_pkg.sv]
// Constants for the sync pin port configuration block
package spc_pkg;

    // Register subaddresses
    localparam logic [7:0] SPC_ADDR_SYNC_PIN_CONFIG = 8'h6b;
    localparam logic [7:0] SPC_ADDR_HORIZ_TRIGGER_PHASE_LO        = 8'h6c;
    localparam logic [7:0] SPC_ADDR_HORIZ_TRIGGER_PHASE_HI        = 8'h6d;

    // Field positions of the sync pin configuration register
    localparam int SPC_BIT_TYPE_HI      = 7;
    localparam int SPC_BIT_TYPE_LO      = 6;
    localparam int SPC_BIT_HSRC         = 5;
    localparam int SPC_BIT_ONE_DIR      = 4;
    localparam int SPC_BIT_ONE_POL      = 3;
    localparam int SPC_BIT_CBLANK       = 2;
    localparam int SPC_BIT_TWO_DIR      = 1;
    localparam int SPC_BIT_TWO_POL      = 0;

    // Field positions of the upper trigger register
    localparam int SPC_HORIZ_TRIGGER_PHASE_HI_MSB     = 7;
    localparam int SPC_HORIZ_TRIGGER_PHASE_HI_LSB     = 5;
    localparam int SPC_VERT_TRIGGER_PHASE_MSB        = 4;

    // Reset values
    localparam logic [7:0]  SPC_CONFIG_RESET = 8'h00;
    localparam logic [10:0] SPC_HORIZ_TRIGGER_PHASE_RESET  = 11'h000;
    localparam logic [4:0]  SPC_VERT_TRIGGER_PHASE_RESET  = 5'h00;

    // Timing counts
    localparam int SPC_LINE_PIXELS       = 1728;
    localparam int SPC_FIELD_HALF_LINES  = 625;
    localparam int SPC_VS_HALF_LINES     = 6;
    localparam logic [3:0] SPC_FIELD_SEQUENCE_SYNC_NTSC  = 4'h4;
    localparam logic [3:0] SPC_FIELD_SEQUENCE_SYNC_PAL   = 4'h8;
    localparam logic [3:0] SPC_FIELD_SEQUENCE_SYNC_SEQUENTIAL_COLOUR_MODE = 4'hc;

    // Signal type on the first sync pin
    typedef enum logic [1:0] {
        SPC_TYPE_VSYNC = 2'b00,
        SPC_TYPE_FRAME = 2'b01,
        SPC_TYPE_FIELD_SEQUENCE_SYNC  = 2'b10,
        SPC_TYPE_NA    = 2'b11
    } spc_type_t;

endpackage

// [rtl/spc_edge_detect.sv]
// Two-flop synchroniser and active edge detector for one sync pin
`timescale 1ns/100ps
module spc_edge_detect
(
    input  wire logic core_clk_i,   // Pixel clock
    input  wire logic reset_i,      // Synchronous reset
    input  wire logic pin_i,        // Raw pin level
    input  wire logic falling_i,    // One selects the falling edge
    output logic      active_o,     // Synchronised level, active high
    output logic      edge_o        // One-cycle pulse on the active edge
);

    logic sync_a;
    logic sync_b;
    logic prev_active;

    // Synchroniser; sync_a feeds sync_b only
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end
        else
        begin
            sync_a <= pin_i;
            sync_b <= sync_a;
        end
    end

    assign active_o = sync_b ^ falling_i;

    // Previous active level for edge finding
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            prev_active <= 1'b1;
        else
            prev_active <= active_o;
    end

    assign edge_o = active_o & ~prev_active;

endmodule // spc_edge_detect

// [sim/spc_sync_master.sv]
// Model of the external sync timing master driving both sync pins
`timescale 1ns/100ps
module spc_sync_master
(
    input  wire logic core_clk_i, // Pixel clock
    output logic      pin_one_o,  // Level driven on the first pin
    output logic      pin_two_o,  // Level driven on the second pin
    output logic      fs_656_o    // Decoded 656 frame sync pulse
);
    // Idle levels at time zero
    initial
    begin
        pin_one_o = 1'b0;
        pin_two_o = 1'b0;
        fs_656_o  = 1'b0;
    end

    // Change a pin level just after an edge and hold it
    task automatic drive(input bit two, input bit lvl);
        @(posedge core_clk_i);
        if (two)
            pin_two_o <= lvl;
        else
            pin_one_o <= lvl;
    endtask

    // One-cycle frame sync pulse
    task automatic frame_sync();
        @(posedge core_clk_i);
        fs_656_o <= 1'b1;
        @(posedge core_clk_i);
        fs_656_o <= 1'b0;
    endtask
endmodule // spc_sync_master

// [sim/spc_sync_port_tb.sv]
// Self-checking testbench of the sync pin port block
`timescale 1ns/100ps
module spc_sync_port_tb
    import spc_pkg::*;
;
    logic        core_clk_i, reset_i, reg_wr_i, reg_rd_i, method, phase_alternation_mode, sequential_colour_mode;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [8:0]  first_line, last_line;
    logic [10:0] p_start, p_end;
    logic        one_o, one_oe_n, two_o, two_oe_n, m_one, m_two, fs_656, pin_one, pin_two;
    logic        h_ev, v_ev, field_odd, int_blank;
    logic [10:0] hpos, h_pos;
    logic [9:0]  half_line, v_line;
    int          h_cnt = 0, v_cnt = 0, err_count = 0, total_checks = 0;

    // Wire level: the design drives while its enable is low
    assign pin_one = one_oe_n ? m_one : one_o;
    assign pin_two = two_oe_n ? m_two : two_o;

    spc_sync_master m (.core_clk_i(core_clk_i), .pin_one_o(m_one), .pin_two_o(m_two), .fs_656_o(fs_656));

    spc_sync_port #(.LINE_PIXELS(64), .FIELD_HALF_LINES(21), .VS_HALF_LINES(2)) dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .sync_method_select_i(method), .frame_sync_656_i(fs_656), .phase_alternation_mode_i(phase_alternation_mode),
        .sequential_colour_mode_i(sequential_colour_mode), .pulse_start_position_i(p_start), .pulse_end_position_i(p_end),
        .first_active_line_i(first_line), .last_active_line_i(last_line), .sync_pin_one_i(pin_one),
        .sync_pin_one_o(one_o), .sync_pin_one_oe_n_o(one_oe_n), .sync_pin_two_i(pin_two),
        .sync_pin_two_o(two_o), .sync_pin_two_oe_n_o(two_oe_n), .h_sync_event_o(h_ev),
        .v_sync_event_o(v_ev), .hpos_o(hpos), .half_line_o(half_line), .field_odd_o(field_odd),
        .int_blank_o(int_blank));

    // Clock of 10 ns
    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // Count sync events and note the counter loads
    always @(posedge core_clk_i)
    begin
        if (h_ev === 1'b1)
        begin
            h_cnt <= h_cnt + 1;
            h_pos <= hpos;
        end
        if (v_ev === 1'b1)
        begin
            v_cnt <= v_cnt + 1;
            v_line <= half_line;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        check(16'(reg_rdata_o), 16'(exp));
    endtask

    task automatic t_regs();
        rd_chk(8'h6b, 8'h00);
        check(16'(one_oe_n), 16'h1);
        check(16'(two_oe_n), 16'h1);
        wr(8'h55, 8'hff);
        rd_chk(8'h55, 8'h00);
        rd_chk(8'h6b, 8'h00);
        wr(8'h6b, 8'h02);
        check(16'(one_oe_n), 16'h1);
        check(16'(two_oe_n), 16'h0);
        wr(8'h6b, 8'h10);
        check(16'(one_oe_n), 16'h0);
        check(16'(two_oe_n), 16'h1);
        rd_chk(8'h6b, 8'h10);
        wr(8'h6c, 8'h25);
        wr(8'h6d, 8'h03);
        rd_chk(8'h6c, 8'h25);
        rd_chk(8'h6d, 8'h03);
        $display("done registers");
    endtask

    // Edge on one pin, then the count of events after it
    task automatic edge_chk(input bit two, input bit lvl, input int dh, input int dv);
        int h0, v0;
        h0 = h_cnt;
        v0 = v_cnt;
        m.drive(two, lvl);
        repeat (8) @(posedge core_clk_i);
        check(16'(h_cnt - h0), 16'(dh));
        check(16'(v_cnt - v0), 16'(dv));
    endtask

    task automatic t_pin_one(input bit pol);
        wr(8'h6b, {4'h0, pol, 3'h0});
        m.drive(0, pol);
        repeat (8) @(posedge core_clk_i);
        edge_chk(0, !pol, 1, 1);
        check(16'(h_pos), 16'h0025);
        check(16'(v_line), 16'h0003);
        edge_chk(0, pol, 0, 0);
        $display("done pin one input");
    endtask

    task automatic t_pin_two(input bit hsrc, input bit cb, input bit pol);
        wr(8'h6b, {2'b00, hsrc, 2'b00, cb, 1'b0, pol});
        m.drive(1, pol);
        repeat (8) @(posedge core_clk_i);
        edge_chk(1, !pol, int'(hsrc), 0);
        check(16'(int_blank), 16'(cb));
        edge_chk(1, pol, 0, 0);
        check(16'(int_blank), 16'h0);
        $display("done pin two input");
    endtask

    task automatic t_656();
        int h0;
        wr(8'h6b, 8'h00);
        m.drive(0, 1'b0);
        method <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        edge_chk(0, 1'b1, 0, 0);
        h0 = h_cnt;
        m.frame_sync();
        repeat (8) @(posedge core_clk_i);
        check(16'(h_cnt - h0), 16'h0001);
        edge_chk(0, 1'b0, 0, 0);
        method <= 1'b0;
        $display("done 656 sync");
    endtask

    // Active cycles of a pin output over a whole number of periods
    task automatic t_out(input bit two, input logic [7:0] cfg, input logic [8:0] fl, input bit p,
                         input bit s, input int n, input int exp);
        int c;
        c = 0;
        first_line <= fl;
        phase_alternation_mode <= p;
        sequential_colour_mode <= s;
        wr(8'h6b, cfg);
        repeat (8) @(posedge core_clk_i);
        repeat (n)
        begin
            @(posedge core_clk_i);
            if ((two ? two_o : one_o) === 1'b1)
                c++;
        end
        check(16'(c), 16'(exp));
        $display("done pin output %h", cfg);
    endtask

    // Field parity is high for one field out of two
    task automatic t_field();
        int c;
        c = 0;
        repeat (1344)
        begin
            @(posedge core_clk_i);
            if (field_odd === 1'b1)
                c++;
        end
        check(16'(c), 16'h02a0);
        $display("done field parity");
    endtask

    // Watchdog
    initial
    begin
        repeat (90000) @(posedge core_clk_i);
        err_count++;
        end_of_test();
    end

    // Main sequence
    initial
    begin
        {reg_wr_i, reg_rd_i, method, phase_alternation_mode, sequential_colour_mode} = 5'h00;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        first_line = 9'h000;
        last_line = 9'h1ff;
        p_start = 11'h00a;
        p_end = 11'h01e;
        reset_i = 1'b1;
        repeat (10) @(posedge core_clk_i);
        reset_i <= 1'b0;
        t_regs();
        t_pin_one(0);
        t_pin_one(1);
        t_pin_two(0, 0, 0);
        t_pin_two(1, 0, 1);
        t_pin_two(1, 1, 0);
        t_pin_two(0, 1, 1);
        t_656();
        t_out(1, 8'h02, 9'h000, 0, 0, 64, 20);
        t_out(1, 8'h03, 9'h000, 0, 0, 64, 44);
        t_out(1, 8'h02, 9'h1ff, 0, 0, 64, 20);
        t_out(1, 8'h06, 9'h1ff, 0, 0, 64, 0);
        t_out(1, 8'h06, 9'h000, 0, 0, 64, 20);
        last_line <= 9'h000;
        t_out(1, 8'h06, 9'h000, 0, 0, 672, 20);
        last_line <= 9'h1ff;
        t_out(0, 8'h10, 9'h000, 0, 0, 672, 64);
        t_out(0, 8'h18, 9'h000, 0, 0, 672, 608);
        t_out(0, 8'h50, 9'h000, 0, 0, 1344, 672);
        t_field();
        t_out(0, 8'h90, 9'h000, 0, 0, 16128, 384);
        t_out(0, 8'h90, 9'h000, 1, 0, 16128, 192);
        t_out(0, 8'h90, 9'h000, 0, 1, 16128, 128);
        end_of_test();
    end
endmodule // spc_sync_port_tb
